// File: atxc_cfg.svh
// Constants for the transmit control register and ARINC transmitter
//
// Contract
// (R01) Op-code 0x08 writes, 0x84 reads back the stored control byte.
// (R02) Bit 7 set floats the line driver outputs.
// (R03) Bit 6 set reverses the 8 label bits of each sent word.
// (R04) Bit 5 clear: words wait for op-code 0x40 before being sent.
// (R05) Bit 5 set: words are sent as soon as they are present.
// (R06) Bit 4 set loops transmitter output to both receiver inputs.
// (R07) In self-test the external receive pins are ignored.
// (R08) In self-test the line driver holds the NULL level.
// (R09) Bit 2 clear: transmitted bit 32 is plain data.
// (R10) Bit 2 set: transmitted bit 32 is replaced by parity.
// (R11) Bit 3 clear gives odd parity, set gives even parity.
// (R12) Bit 0 clear high speed, set low speed at one eighth.
// (R13) Parity covers bits 1 to 31 so the word has chosen parity.
`ifndef ATXC_CFG_SVH
`define ATXC_CFG_SVH

// SPI op-codes
`define ATXC_OP_CTRL_WR   8'h08
`define ATXC_OP_CTRL_RD   8'h84
`define ATXC_OP_TX_ENABLE 8'h40

// Control register layout and reset value
`define ATXC_CTRL_RESET       8'h00
`define ATXC_BIT_DRIVER_FLOAT 7
`define ATXC_BIT_LABEL_REV    6
`define ATXC_BIT_SEND_POLICY  5
`define ATXC_BIT_LOOPBACK     4
`define ATXC_BIT_PAR_POLARITY 3
`define ATXC_BIT_PAR_INSERT   2
`define ATXC_BIT_RATE         0

// SPI frame bit counts
`define ATXC_SPI_OP_LAST   5'h07
`define ATXC_SPI_DATA_LAST 5'h0f
`define ATXC_SPI_CNT_SAT   5'h10

// Word format
`define ATXC_WORD_BITS  32
`define ATXC_LABEL_BITS 8
`define ATXC_GAP_BITS   4

// Timing: high speed bit time, clock period and low speed divider
`define ATXC_HS_BIT_NS    10000
`define ATXC_CLK_NS       40
`define ATXC_HS_HALF_CYC  ((`ATXC_HS_BIT_NS / 2 + `ATXC_CLK_NS - 1) / `ATXC_CLK_NS)
`define ATXC_LS_DIV       8
`define ATXC_HALF_W       12

`endif

// File: atxc_pkg.sv
// Types for the ARINC transmit control block
`include "atxc_cfg.svh"

package atxc_pkg;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_SEND = 3'b010,
		TX_GAP  = 3'b100
	} atxc_tx_state_t;

	typedef struct packed {
		logic [4:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] opcode;
		logic [7:0] out_sh;
		logic       miso;
	} atxc_spi_frame_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic       wr_tgl;
		logic       cmd_tgl;
	} atxc_spi_keep_t;

	typedef struct packed {
		atxc_tx_state_t           state;
		logic [7:0]               ctrl;
		logic                     wr_seen;
		logic                     cmd_seen;
		logic                     armed;
		logic                     slow;
		logic [`ATXC_WORD_BITS-1:0] word;
		logic [4:0]               bit_idx;
		logic [3:0]               gap_cnt;
		logic [`ATXC_HALF_W-1:0]  half;
		logic                     phase;
		logic                     lvl_a;
		logic                     lvl_b;
		logic                     taken;
		logic                     busy;
		logic                     line_a;
		logic                     line_b;
		logic                     line_oe;
		logic [3:0]               rcv;
	} atxc_core_t;

endpackage

// File: atxc_sync.sv
// Two flip-flop synchroniser with clock enable
`timescale 1ns/10ps
`default_nettype none

module atxc_sync #(
	parameter int W = 1
) (
	// System
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_reg <= '0;
			q        <= '0;
		end else if (ce) begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end

endmodule

`default_nettype wire

// File: atxc_top.sv
// Transmit control register with SPI access and ARINC word transmitter
`timescale 1ns/10ps
`default_nettype none
`include "atxc_cfg.svh"

module atxc_top
	import atxc_pkg::*;
#(
	parameter int HALF_HS_CYC = `ATXC_HS_HALF_CYC,
	parameter int LS_DIV      = `ATXC_LS_DIV
) (
	// System clock domain
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// SPI host port
	input  wire logic        spi_sck,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_mosi,
	output logic             spi_miso,
	// Transmit FIFO side
	input  wire logic [31:0] tx_data,
	input  wire logic        tx_data_valid,
	output logic             tx_data_taken,
	output logic             tx_busy,
	// Line driver
	output logic             line_a,
	output logic             line_b,
	output logic             line_oe,
	// External receive pins
	input  wire logic        rx1_a,
	input  wire logic        rx1_b,
	input  wire logic        rx2_a,
	input  wire logic        rx2_b,
	// Receiver inputs after loopback select
	output logic             rcv1_a,
	output logic             rcv1_b,
	output logic             rcv2_a,
	output logic             rcv2_b
);

	localparam logic [`ATXC_HALF_W-1:0] HALF_HS_LAST =
		`ATXC_HALF_W'(HALF_HS_CYC - 1);
	localparam logic [`ATXC_HALF_W-1:0] HALF_LS_LAST =
		`ATXC_HALF_W'(HALF_HS_CYC * LS_DIV - 1);
	localparam logic [4:0] LAST_BIT = 5'(`ATXC_WORD_BITS - 1);
	localparam logic [3:0] GAP_LAST = 4'(`ATXC_GAP_BITS * 2 - 1);

	////////////////////////////////////////////////////////////////////////
	// SPI domain state

	atxc_spi_frame_t sf_reg;
	atxc_spi_frame_t sf_next;
	atxc_spi_keep_t  sk_reg;
	atxc_spi_keep_t  sk_next;
	logic            frame_rst_n;
	logic [7:0]      rx_byte;

	assign frame_rst_n = rstn & ~spi_cs_n;
	assign rx_byte     = {sf_reg.shift[6:0], spi_mosi};

	always_comb begin
		sf_next = sf_reg;
		sk_next = sk_reg;
		sf_next.shift = rx_byte;
		sf_next.out_sh = {sf_reg.out_sh[6:0], 1'b0};
		sf_next.miso = sf_reg.out_sh[7];
		if (sf_reg.bit_cnt != `ATXC_SPI_CNT_SAT) begin
			sf_next.bit_cnt = sf_reg.bit_cnt + 5'h01;
		end
		if (sf_reg.bit_cnt >= `ATXC_SPI_DATA_LAST) begin
			sf_next.miso = 1'b0;
		end
		if (sf_reg.bit_cnt == `ATXC_SPI_OP_LAST) begin
			sf_next.opcode = rx_byte;
			sf_next.miso = 1'b0;
			sf_next.out_sh = 8'h00;
			if (rx_byte == `ATXC_OP_CTRL_RD) begin
				sf_next.miso = sk_reg.ctrl[7]; // R01
				sf_next.out_sh = {sk_reg.ctrl[6:0], 1'b0}; // R01
			end
			if (rx_byte == `ATXC_OP_TX_ENABLE) begin
				sk_next.cmd_tgl = ~sk_reg.cmd_tgl; // R04
			end
		end
		if (sf_reg.bit_cnt == `ATXC_SPI_DATA_LAST &&
			sf_reg.opcode == `ATXC_OP_CTRL_WR) begin
			sk_next.ctrl = rx_byte; // R01
			sk_next.wr_tgl = ~sk_reg.wr_tgl; // R01
		end
	end

	// Frame state, cleared whenever chip select is high
	always_ff @(posedge spi_sck or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			sf_reg <= '0;
		end else begin
			sf_reg <= sf_next;
		end
	end

	// Stored control byte and event toggles, kept across frames
	always_ff @(posedge spi_sck or negedge rstn) begin
		if (!rstn) begin
			sk_reg <= '{ctrl: `ATXC_CTRL_RESET, wr_tgl: 1'b0, cmd_tgl: 1'b0};
		end else begin
			sk_reg <= sk_next;
		end
	end

	assign spi_miso = sf_reg.miso;

	////////////////////////////////////////////////////////////////////////
	// Crossings into the system domain

	logic [1:0] tgl_s;
	logic [3:0] rx_s;

	atxc_sync #(
		.W (2)
	) u_tgl_sync (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.d    ({sk_reg.cmd_tgl, sk_reg.wr_tgl}),
		.q    (tgl_s)
	);

	atxc_sync #(
		.W (4)
	) u_rx_sync (
		.clk  (clk),
		.rstn (rstn),
		.ce   (ce),
		.d    ({rx2_b, rx2_a, rx1_b, rx1_a}),
		.q    (rx_s)
	);

	////////////////////////////////////////////////////////////////////////
	// Word formatting

	function automatic logic [31:0] fmt_word(
		input logic [31:0] w,
		input logic [7:0]  c
	);
		logic [31:0] o;
		logic        odd_ones;
		o = w;
		if (c[`ATXC_BIT_LABEL_REV]) begin
			for (int i = 0; i < `ATXC_LABEL_BITS; i++) begin
				o[i] = w[`ATXC_LABEL_BITS - 1 - i]; // R03
			end
		end
		odd_ones = ^o[30:0]; // R13
		if (c[`ATXC_BIT_PAR_INSERT]) begin
			if (c[`ATXC_BIT_PAR_POLARITY]) begin
				o[31] = odd_ones; // R10 R11
			end else begin
				o[31] = ~odd_ones; // R10 R11
			end
		end
		return o; // R09
	endfunction

	////////////////////////////////////////////////////////////////////////
	// System domain state

	atxc_core_t r_reg;
	atxc_core_t r_next;
	logic       wr_ev;
	logic       cmd_ev;
	logic       may_send;
	logic       half_end;
	logic       loop_on;

	assign wr_ev  = tgl_s[0] ^ r_reg.wr_seen;
	assign cmd_ev = tgl_s[1] ^ r_reg.cmd_seen;

	always_comb begin
		r_next = r_reg;
		r_next.taken = 1'b0;
		if (wr_ev) begin
			r_next.wr_seen = tgl_s[0];
			r_next.ctrl = sk_reg.ctrl; // R01
		end
		if (cmd_ev) begin
			r_next.cmd_seen = tgl_s[1];
		end
		may_send = r_reg.ctrl[`ATXC_BIT_SEND_POLICY] || r_reg.armed; // R04 R05
		if (r_reg.slow) begin
			half_end = r_reg.half == HALF_LS_LAST; // R12
		end else begin
			half_end = r_reg.half == HALF_HS_LAST; // R12
		end
		unique case (r_reg.state)
			TX_IDLE: begin
				r_next.half = '0;
				r_next.phase = 1'b0;
				if (tx_data_valid && may_send) begin
					r_next.state = TX_SEND;
					r_next.word = fmt_word(tx_data, r_reg.ctrl);
					r_next.slow = r_reg.ctrl[`ATXC_BIT_RATE]; // R12
					r_next.bit_idx = '0;
					r_next.taken = 1'b1;
				end else if (!tx_data_valid) begin
					r_next.armed = 1'b0; // R04
				end
			end
			TX_SEND: begin
				r_next.half = r_reg.half + `ATXC_HALF_W'(1);
				if (half_end) begin
					r_next.half = '0;
					r_next.phase = ~r_reg.phase;
					if (r_reg.phase) begin
						r_next.word = {1'b0, r_reg.word[31:1]};
						r_next.bit_idx = r_reg.bit_idx + 5'h01;
						if (r_reg.bit_idx == LAST_BIT) begin
							r_next.state = TX_GAP;
							r_next.gap_cnt = '0;
						end
					end
				end
			end
			TX_GAP: begin
				r_next.half = r_reg.half + `ATXC_HALF_W'(1);
				if (half_end) begin
					r_next.half = '0;
					r_next.gap_cnt = r_reg.gap_cnt + 4'h1;
					if (r_reg.gap_cnt == GAP_LAST) begin
						r_next.state = TX_IDLE;
					end
				end
			end
		endcase
		// A command arriving as the queue drains still arms
		if (cmd_ev) begin
			r_next.armed = 1'b1; // R04
		end
		r_next.lvl_a = r_next.state == TX_SEND && !r_next.phase &&
			r_next.word[0];
		r_next.lvl_b = r_next.state == TX_SEND && !r_next.phase &&
			!r_next.word[0];
		r_next.busy = r_next.state != TX_IDLE;
		loop_on = r_next.ctrl[`ATXC_BIT_LOOPBACK];
		r_next.line_oe = !r_next.ctrl[`ATXC_BIT_DRIVER_FLOAT]; // R02
		r_next.line_a = r_next.lvl_a && !loop_on; // R08
		r_next.line_b = r_next.lvl_b && !loop_on; // R08
		if (loop_on) begin
			r_next.rcv = {r_next.lvl_b, r_next.lvl_a,
				r_next.lvl_b, r_next.lvl_a}; // R06 R07
		end else begin
			r_next.rcv = rx_s;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '{
				state:   TX_IDLE,
				ctrl:    `ATXC_CTRL_RESET,
				default: '0
			};
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign tx_data_taken = r_reg.taken;
	assign tx_busy       = r_reg.busy;
	assign line_a        = r_reg.line_a;
	assign line_b        = r_reg.line_b;
	assign line_oe       = r_reg.line_oe;
	assign rcv1_a        = r_reg.rcv[0];
	assign rcv1_b        = r_reg.rcv[1];
	assign rcv2_a        = r_reg.rcv[2];
	assign rcv2_b        = r_reg.rcv[3];

endmodule

`default_nettype wire

// File: atxc_top_end.sv
// Intentionally empty companion file
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: atxc_props.sv
// Port assertions for the transmit control block
`timescale 1ns/10ps
`default_nettype none

module atxc_props #(
	parameter int HALF_HS_CYC = 2,
	parameter int LS_DIV      = 8
) (
	// Observed ports
	input wire logic clk,
	input wire logic rstn,
	input wire logic tx_data_valid,
	input wire logic tx_data_taken,
	input wire logic tx_busy,
	input wire logic line_a,
	input wire logic line_b
);
	int busy_cnt;

	////////////////////////////////////////////////////////////////////
	// Length of the current busy stretch
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			busy_cnt <= 0;
		else
			busy_cnt <= tx_busy ? busy_cnt + 1 : 0;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	////////////////////////////////////////////////////////////////////
	chk_take_pulse: assert property (
		tx_data_taken |=> !tx_data_taken) else $error("taken held");
	chk_take_starts: assert property (
		tx_data_taken |-> $rose(tx_busy)) else $error("take while busy");
	chk_take_valid: assert property (
		tx_data_taken |-> $past(tx_data_valid)) else $error("take no data");
	chk_idle_null: assert property (
		!tx_busy |-> !line_a && !line_b) else $error("line not null");
	chk_no_both: assert property (
		!(line_a && line_b)) else $error("both line outputs high");
	chk_half_min: assert property (
		$rose(line_a) |=> line_a) else $error("half bit too short");
	chk_rz_null: assert property (
		$fell(line_b) |-> !line_a) else $error("no return to null");
	chk_busy_len: assert property (
		$fell(tx_busy) |-> busy_cnt >= 72 * HALF_HS_CYC - 1
		&& busy_cnt <= 72 * HALF_HS_CYC * LS_DIV + 1)
		else $error("word length wrong");

	cov_take: cover property (tx_data_taken);
	cov_done: cover property ($fell(tx_busy));
	cov_low: cover property ($rose(line_b));
endmodule

bind atxc_top atxc_props #(.HALF_HS_CYC(HALF_HS_CYC), .LS_DIV(LS_DIV))
	u_props (.clk(clk), .rstn(rstn), .tx_data_valid(tx_data_valid),
	.tx_data_taken(tx_data_taken), .tx_busy(tx_busy),
	.line_a(line_a), .line_b(line_b));
`default_nettype wire

// File: atxc_spi_host.sv
// SPI host model for the control port
`timescale 1ns/10ps
`default_nettype none

module atxc_spi_host (
	// SPI pins
	output logic      spi_sck,
	output logic      spi_cs_n,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// One frame: op-code then data byte, MSB first
	task automatic xfer(input logic [7:0] op, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] f;
		f = {op, d};
		q = 8'h00;
		#203 spi_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi = f[i];
			#7.5 spi_sck = 1'b1;
			#7.5 spi_sck = 1'b0;
			if (i >= 1 && i <= 8)
				q = {q[6:0], spi_miso};
		end
		#7.5 spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi;
	endtask
endmodule
`default_nettype wire

// File: tb_atxc_top.sv
// Testbench for the transmit control block
`timescale 1ns/10ps
`default_nettype none
`include "atxc_cfg.svh"

module tb_atxc_top;
	logic        clk, rstn, tx_data_valid, rx1_a;
	logic [31:0] tx_data, w;
	logic        sck, cs_n, mosi, miso, taken, busy;
	logic        la, lb, oe, r1a, r1b, r2a, r2b;
	logic [7:0]  q;
	int          n_mismatch, cmp_count, len, ok, seen, seen2;
	logic [7:0]  cfg [4] = '{8'h20, 8'h24, 8'h2c, 8'h64};

	atxc_top #(.HALF_HS_CYC(2)) uut (
		.clk(clk), .rstn(rstn), .ce(1'b1), .spi_sck(sck),
		.spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
		.tx_data(tx_data), .tx_data_valid(tx_data_valid),
		.tx_data_taken(taken), .tx_busy(busy), .line_a(la),
		.line_b(lb), .line_oe(oe), .rx1_a(rx1_a), .rx1_b(1'b0),
		.rx2_a(rx1_a), .rx2_b(1'b0), .rcv1_a(r1a), .rcv1_b(r1b),
		.rcv2_a(r2a), .rcv2_b(r2b));
	atxc_spi_host host (.spi_sck(sck), .spi_cs_n(cs_n),
		.spi_mosi(mosi), .spi_miso(miso));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] exp_word(logic [31:0] d,
		logic [7:0] c);
		logic [31:0] r;
		r = d;
		if (c[6]) begin
			for (int i = 0; i < 8; i++) begin
				r[i] = d[7 - i];
			end
		end
		if (c[2])
			r[31] = c[3] ~^ (^r[30:0]);
		return r;
	endfunction

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch at %0t: %h expected %h", $time, s, e);
		end
	endtask

	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] d);
		host.xfer(`ATXC_OP_CTRL_WR, d, q);
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic wait_taken(input int lim);
		ok = 0;
		for (int i = 0; i < lim && !ok; i++) begin
			@(negedge clk);
			ok = (taken === 1'b1);
		end
	endtask

	task automatic load(input logic [31:0] d);
		@(posedge clk);
		tx_data <= d;
		tx_data_valid <= 1'b1;
	endtask

	task automatic drop;
		@(posedge clk);
		tx_data_valid <= 1'b0;
		for (int i = 0; i < 300 && busy !== 1'b0; i++)
			@(negedge clk);
		if (busy !== 1'b0) begin
			n_mismatch++;
			end_sim();
		end
	endtask

	// Decode one word from the line, timing the first half bit
	task automatic get_word;
		int t;
		w = '0;
		len = 0;
		t = 0;
		for (int b = 0; b < 32; b++) begin
			while (!(la | lb) && t < 9000) begin
				@(negedge clk);
				t++;
			end
			w[b] = la;
			while ((la | lb) && t < 9000) begin
				if (b == 0)
					len++;
				@(negedge clk);
				t++;
			end
		end
		if (t >= 9000) begin
			n_mismatch++;
			end_sim();
		end
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		tx_data = '0;
		tx_data_valid = 1'b0;
		rx1_a = 1'b0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		host.xfer(`ATXC_OP_CTRL_RD, 8'h00, q);
		check(q, `ATXC_CTRL_RESET);
		for (int i = 0; i < 2; i++) begin
			wr(8'ha5 ^ {8{i[0]}});
			host.xfer(`ATXC_OP_CTRL_RD, 8'h00, q);
			check(q, 8'ha5 ^ {8{i[0]}});
		end
		$display("register test done");
		wr(8'h00);
		load(32'h8000_00c1);
		wait_taken(30);
		check(ok, 0);
		fork
			host.xfer(`ATXC_OP_TX_ENABLE, 8'h00, q);
			wait_taken(60);
		join
		check(ok, 1);
		get_word();
		check(w, 32'h8000_00c1);
		drop();
		$display("command test done");
		for (int i = 0; i < 4; i++) begin
			wr(cfg[i]);
			load(32'h8000_00c1);
			wait_taken(40);
			check(ok, 1);
			get_word();
			check(w, exp_word(32'h8000_00c1, cfg[i]));
			check(len, 2);
			drop();
		end
		wr(8'h21);
		load(32'h0000_00ff);
		wait_taken(40);
		check(ok, 1);
		get_word();
		check(len, 2 * `ATXC_LS_DIV);
		drop();
		$display("format test done");
		wr(8'h30);
		@(posedge clk);
		rx1_a <= 1'b1;
		repeat (6) @(negedge clk);
		check(r1a, 1'b0);
		check(r2a, 1'b0);
		load(32'h8000_00c1);
		wait_taken(40);
		check(ok, 1);
		len = 0;
		seen = 0;
		seen2 = 0;
		for (int i = 0; i < 150; i++) begin
			@(negedge clk);
			if (la | lb)
				len++;
			if (r1a | r1b)
				seen = 1;
			if (r2a | r2b)
				seen2 = 1;
		end
		check(len, 0);
		check(seen, 1);
		check(seen2, 1);
		drop();
		$display("loopback test done");
		wr(8'h80);
		check(oe, 1'b0);
		check(r1a, 1'b1);
		check(r2a, 1'b1);
		wr(8'h00);
		check(oe, 1'b1);
		$display("float test done");
		end_sim();
	end
endmodule
`default_nettype wire
